// ===== bench/etpec_phy_model.sv
`timescale 1ns/1ps
module etpec_phy_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       tx_en_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic [7:0] col_at_i,
	input  wire logic [7:0] col_n_i,
	output logic            collision_o,
	output logic [7:0]      good_o,
	output logic [7:0]      coll_o,
	output logic [7:0]      len_o,
	output logic [7:0]      first_o
);
	logic [7:0] idx_reg;
	logic       hit_reg;
	// One-cycle collision pulse; a held level would leak into the retry
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			idx_reg <= 8'h00;
			hit_reg <= 1'b0;
			collision_o <= 1'b0;
			good_o <= 8'h00;
			coll_o <= 8'h00;
			len_o <= 8'h00;
			first_o <= 8'h00;
		end
		else
		begin
			idx_reg <= tx_en_i ? idx_reg + 8'h01 : 8'h00;
			collision_o <= tx_en_i && idx_reg == col_at_i && coll_o < col_n_i && !hit_reg;
			if (collision_o)
				hit_reg <= 1'b1;
			if (tx_en_i && idx_reg == 8'h00)
				first_o <= tx_data_i;
			if (!tx_en_i && idx_reg != 8'h00)
			begin
				len_o <= idx_reg;
				hit_reg <= 1'b0;
				if (hit_reg)
					coll_o <= coll_o + 8'h01;
				else
					good_o <= good_o + 8'h01;
			end
		end
	end
endmodule

// ===== bench/tb_etpec_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; \
	$display("mismatch %s expected %0h seen %0h", nm, e, s); end end
module tb_etpec_top;
	logic        clk_i, rst_i, cyc, stb, we, lv, ll, la, fd, pr, fr, col;
	logic [3:0]  adr, sel;
	logic [31:0] dat, wb_dat_o, q;
	logic        wb_ack_o, load_ready_o, tx_en_o;
	logic [7:0]  ld, tx_data_o, col_at, col_n, good_o, coll_o, len_o, first_o, g, c;
	int          n_fail, checked;
	etpec_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.load_valid_i(lv), .load_data_i(ld), .load_last_i(ll), .load_asis_i(la),
		.load_ready_o(load_ready_o), .tx_en_o(tx_en_o), .tx_data_o(tx_data_o), .collision_i(col),
		.full_duplex_i(fd), .pause_rx_i(pr), .flow_req_i(fr));
	etpec_phy_model phy (.clk_i(clk_i), .rst_i(rst_i), .tx_en_i(tx_en_o), .tx_data_i(tx_data_o),
		.col_at_i(col_at), .col_n_i(col_n), .collision_o(col), .good_o(good_o), .coll_o(coll_o),
		.len_o(len_o), .first_o(first_o));
	task automatic complete_run();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h000000, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic send(input int n, input logic asis);
		for (int i = 0; i < n; i++)
		begin
			lv <= 1'b1;
			ld <= 8'(i);
			ll <= (i == n - 1);
			la <= (i == 0) && asis;
			do @(posedge clk_i); while (load_ready_o !== 1'b1);
		end
		lv <= 1'b0;
		ll <= 1'b0;
	endtask
	task automatic wait_good(input logic [7:0] t);
		for (int k = 0; k < 3000 && good_o !== t; k++)
			@(posedge clk_i);
	endtask
	task automatic t_regs();
		for (int i = 0; i < 4; i++)
		begin
			wb(1'b0, 4'(i * 4), 8'h00);
			`CHK("reset value", 32'h00000000, q)
		end
		wb(1'b1, etpec_pkg::ADR_PARAM, 8'hFF);
		wb(1'b0, etpec_pkg::ADR_PARAM, 8'h00);
		`CHK("parameters", 32'h0000001F, q)
		wb(1'b1, etpec_pkg::ADR_STOP, 8'hFF);
		wb(1'b0, etpec_pkg::ADR_STOP, 8'h00);
		`CHK("stop mode", 32'h00000007, q)
		wb(1'b0, 4'h2, 8'h00);
		`CHK("unmapped", 32'h00000000, q)
		wb(1'b1, etpec_pkg::ADR_PARAM, 8'h00);
		wb(1'b1, etpec_pkg::ADR_STOP, 8'h00);
	endtask
	task automatic t_len();
		logic [7:0] p [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h02, 8'h01};
		logic       a [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
		logic [7:0] e [6] = '{8'h40, 8'h0E, 8'h0A, 8'h0A, 8'h40, 8'h40};
		for (int i = 0; i < 6; i++)
		begin
			wb(1'b1, etpec_pkg::ADR_PARAM, p[i]);
			g = good_o;
			send(10, a[i]);
			wait_good(g + 8'h01);
			`CHK("frame length", e[i], len_o)
		end
		wb(1'b1, etpec_pkg::ADR_PARAM, 8'h00);
	endtask
	task automatic t_spm();
		wb(1'b1, etpec_pkg::ADR_PARAM, 8'h10);
		g = good_o;
		send(10, 1'b0);
		repeat (3) @(posedge clk_i);
		`CHK("load ready held", 1'b0, load_ready_o)
		wait_good(g + 8'h01);
		send(10, 1'b0);
		wait_good(g + 8'h02);
		`CHK("frames", g + 8'h02, good_o)
		wb(1'b1, etpec_pkg::ADR_PARAM, 8'h00);
	endtask
	task automatic t_pause();
		wb(1'b1, etpec_pkg::ADR_PARAM, 8'h04);
		fd <= 1'b1;
		pr <= 1'b1;
		g = good_o;
		send(10, 1'b0);
		repeat (100) @(posedge clk_i);
		`CHK("frames paused", g, good_o)
		pr <= 1'b0;
		wait_good(g + 8'h01);
		`CHK("frames resumed", g + 8'h01, good_o)
		fd <= 1'b0;
		wb(1'b1, etpec_pkg::ADR_PARAM, 8'h00);
	endtask
	task automatic t_resume();
		fr <= 1'b1;
		repeat (8) @(posedge clk_i);
		g = good_o;
		fr <= 1'b0;
		wait_good(g + 8'h01);
		`CHK("resume length", 8'h40, len_o)
		`CHK("resume first byte", 8'h01, first_o)
		wb(1'b1, etpec_pkg::ADR_PARAM, 8'h08);
		fr <= 1'b1;
		repeat (8) @(posedge clk_i);
		fr <= 1'b0;
		repeat (150) @(posedge clk_i);
		`CHK("resume suppressed", g + 8'h01, good_o)
		wb(1'b1, etpec_pkg::ADR_PARAM, 8'h00);
	endtask
	task automatic t_halt(input logic [7:0] mode, input logic [7:0] at, input int n,
		input int len);
		// Collision pattern first, then a halting packet, status, clear and restart
		wb(1'b1, etpec_pkg::ADR_STOP, mode);
		c = coll_o;
		col_at <= at;
		col_n <= c + 8'(n);
		send(len, 1'b0);
		repeat (400) @(posedge clk_i);
		`CHK("collided frames", c + 8'(n), coll_o)
		wb(1'b0, etpec_pkg::ADR_CTRL, 8'h00);
		`CHK("halted", 32'h00000001, q)
		wb(1'b0, etpec_pkg::ADR_ERR, 8'h00);
		`CHK("error status", {24'h000000, mode}, q)
		wb(1'b1, etpec_pkg::ADR_ERR, 8'hFF);
		wb(1'b1, etpec_pkg::ADR_CTRL, 8'h01);
		wb(1'b0, etpec_pkg::ADR_CTRL, 8'h00);
		`CHK("restarted", 32'h00000000, q)
		wb(1'b1, etpec_pkg::ADR_STOP, 8'h00);
		c = coll_o;
		g = good_o;
		col_n <= c + 8'(n + 4);
		send(len, 1'b0);
		send(10, 1'b0);
		wait_good(g + 8'h01);
		`CHK("next frame length", 8'h40, len_o)
		`CHK("retries", c + ((mode == 8'h02) ? 8'h01 : 8'(n + 4)), coll_o)
	endtask
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial
	begin
		#500000;
		n_fail++;
		complete_run();
	end
	initial
	begin
		{cyc, stb, we, lv, ll, la, fd, pr, fr} = 9'h000;
		adr = 4'h0;
		sel = 4'hF;
		dat = 32'h00000000;
		ld = 8'h00;
		col_at = 8'h00;
		col_n = 8'h00;
		n_fail = 0;
		checked = 0;
		rst_i = 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_len();
		t_spm();
		t_pause();
		t_resume();
		t_halt(8'h02, 8'h46, 1, 80);
		t_halt(8'h04, 8'h02, 16, 10);
		complete_run();
	end
endmodule

// ===== src/etpec_pkg.sv
package etpec_pkg;
	localparam int DATA_W = 8;
	localparam int FIFO_W = 10;
	localparam int FIFO_D = 16;
	localparam int LVL_W = 5;
	localparam int CNT_W = 7;
	localparam int REPLAY_D = 64;
	localparam logic [3:0] ADR_PARAM = 4'h0;
	localparam logic [3:0] ADR_STOP = 4'h4;
	localparam logic [3:0] ADR_ERR = 4'h8;
	localparam logic [3:0] ADR_CTRL = 4'hC;
	localparam logic [7:0] PARAM_MASK = 8'h1F;
	localparam logic [7:0] STOP_MASK = 8'h07;
	localparam logic [7:0] RESET_VAL = 8'h00;
	localparam int B_SPM = 4;
	localparam int B_RESUME_FRAME_SUPPRESS = 3;
	localparam int B_PAUSE = 2;
	localparam int B_NOCRC = 1;
	localparam int B_NOPAD = 0;
	localparam int B_EXC = 2;
	localparam int B_LATE = 1;
	localparam int B_UNF = 0;
	localparam int B_RESTART = 0;
	localparam logic [CNT_W-1:0] MIN_FRAME = 7'h40;
	localparam logic [CNT_W-1:0] PAD_END = 7'h3B;
	localparam logic [CNT_W-1:0] CTL_LAST = 7'h11;
	localparam logic [4:0] MAX_ATTEMPT = 5'h10;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DATA = 3'b001,
		ST_PAD = 3'b010,
		ST_CRC = 3'b011,
		ST_FLUSH = 3'b100,
		ST_GAP = 3'b101,
		ST_HALT = 3'b110
	} etpec_state_type;
	// Resume frame: reserved multicast, control type, pause opcode, zero time
	function automatic logic [7:0] ctl_byte(input logic [CNT_W-1:0] idx);
		logic [7:0] b;
		b = 8'h00;
		case (idx)
			7'h00: b = 8'h01;
			7'h01: b = 8'h80;
			7'h02: b = 8'hC2;
			7'h05: b = 8'h01;
			7'h0C: b = 8'h88;
			7'h0D: b = 8'h08;
			7'h0F: b = 8'h01;
			default: b = 8'h00;
		endcase
		return b;
	endfunction
endpackage

// ===== src/etpec_top.sv
// Overview of operation
// - Single packet loading: no new load until previous packet ends its CRC or is flushed; a no-CRC packet never frees it.
// - Resume frame suppress blocks control frame on flow request deassertion.
// - Pause honour in full duplex holds the start of data packets while pause frames arrive; a resume frame still goes out.
// - Frame check append disable: no pad and no CRC appended.
// - Pass-as-is strobe at packet start overrides both append disables.
// - Pad append disable leaves short packets short; otherwise pad to 64 bytes.
// - Pad append disable is disregarded while frame check append disable is set.
// - Stopping error flushes the transmit FIFO and stops transmission.
// - Each stopping error is recorded in the transmit error status register.
// - Excess collision stop: give up after 16 attempts and stop.
// - Excess collision stop clear: retry after every collision within the first 64 bytes indefinitely.
// - Late collision stop: collision after 64 bytes stops transmission.
// - Late collision stop clear: flush collided packet, go on to next.
// - Underflow stop: FIFO underflow after 64 bytes stops transmission.
// - Underflow stop clear: flush underflowed packet, continue with next.
// - Both control registers are read/write and reset to zero.
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module etpec_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16,
	parameter int LW    = 5
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o,
	output logic [LW-1:0]         level_o
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [LW-2:0]    wr_reg;
	logic [LW-2:0]    rd_reg;
	logic [LW-1:0]    cnt_reg;
	logic             push;
	logic             pop;
	assign in_ready_o = (cnt_reg != LW'(DEPTH));
	assign out_valid_o = (cnt_reg != '0);
	assign out_data_o = mem[rd_reg];
	assign level_o = cnt_reg;
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wr_reg] <= in_data_i;
	end
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			wr_reg <= wr_reg + (LW-1)'(push);
			rd_reg <= rd_reg + (LW-1)'(pop);
			cnt_reg <= cnt_reg + LW'(push) - LW'(pop);
		end
	end
endmodule

module etpec_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        load_valid_i,
	input  wire logic [7:0]  load_data_i,
	input  wire logic        load_last_i,
	input  wire logic        load_asis_i,
	output logic             load_ready_o,
	output logic             tx_en_o,
	output logic [7:0]       tx_data_o,
	input  wire logic        collision_i,
	input  wire logic        full_duplex_i,
	input  wire logic        pause_rx_i,
	input  wire logic        flow_req_i
);
	etpec_pkg::etpec_state_type state_reg;
	logic [7:0]  param_reg;
	logic [7:0]  stop_reg;
	logic [2:0]  err_reg;
	logic        halt_reg;
	logic        ack_reg;
	logic [31:0] dat_reg;
	logic        ready_reg;
	logic        hold_reg;
	logic        first_reg;
	logic        en_reg;
	logic [7:0]  txd_reg;
	logic [3:0]  s1_reg;
	logic [3:0]  s2_reg;
	logic        flow_d_reg;
	logic        resume_reg;
	logic        ctl_reg;
	logic        nocrc_reg;
	logic        nopad_reg;
	logic [6:0]  pos_reg;
	logic [6:0]  sent_reg;
	logic [6:0]  stored_reg;
	logic [4:0]  att_reg;
	logic [31:0] crc_reg;
	logic [1:0]  cidx_reg;
	logic [4:0]  pkt_reg;
	logic [8:0]  replay [etpec_pkg::REPLAY_D];
	logic        wb_req;
	logic        wr_lane;
	logic        push;
	logic        f_valid;
	logic        f_ready;
	logic [9:0]  f_data;
	logic        f_in_ready;
	logic [4:0]  f_level;
	logic        coll;
	logic        fdx;
	logic        pause_blk;
	logic        late;
	logic        from_rep;
	logic        byte_last;
	logic [7:0]  byte_val;
	logic        emit;
	logic [7:0]  emit_b;
	logic        early_coll;
	logic        late_coll;
	logic        underflow;
	logic        stop_ev;
	logic [2:0]  err_set;
	logic        start;
	logic        flow_fall;
	logic        pkt_done;
	logic        retry_set;
	logic        retry_reg;
	etpec_pkg::etpec_state_type state_next;

	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c ^ {24'h000000, d};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ etpec_pkg::CRC_POLY) : (r >> 1);
		return r;
	endfunction

	assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
	// Writes land on the edge at which the master samples ack high
	assign wr_lane = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i & wb_sel_i[0];
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end
		else
		begin
			ack_reg <= wb_req;
			if (wb_req)
			begin
				case (wb_adr_i)
					etpec_pkg::ADR_PARAM: dat_reg <= {24'h000000, param_reg};
					etpec_pkg::ADR_STOP: dat_reg <= {24'h000000, stop_reg};
					etpec_pkg::ADR_ERR: dat_reg <= {29'h00000000, err_reg};
					etpec_pkg::ADR_CTRL: dat_reg <= {31'h00000000, halt_reg};
					default: dat_reg <= 32'h00000000;
				endcase
			end
		end
	end
	// Reserved bits masked on write so they always read back zero
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			param_reg <= etpec_pkg::RESET_VAL;
			stop_reg <= etpec_pkg::RESET_VAL;
		end
		else if (wr_lane && wb_adr_i == etpec_pkg::ADR_PARAM)
			param_reg <= wb_dat_i[7:0] & etpec_pkg::PARAM_MASK;
		else if (wr_lane && wb_adr_i == etpec_pkg::ADR_STOP)
			stop_reg <= wb_dat_i[7:0] & etpec_pkg::STOP_MASK;
	end
	// Write one to clear; a new error in the same cycle still lands
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			err_reg <= 3'h0;
		else if (wr_lane && wb_adr_i == etpec_pkg::ADR_ERR)
			err_reg <= (err_reg & ~wb_dat_i[2:0]) | err_set;
		else
			err_reg <= err_reg | err_set;
	end
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			halt_reg <= 1'b0;
		else if (stop_ev)
			halt_reg <= 1'b1;
		else if (wr_lane && wb_adr_i == etpec_pkg::ADR_CTRL && wb_dat_i[etpec_pkg::B_RESTART])
			halt_reg <= 1'b0;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s1_reg <= 4'h0;
			s2_reg <= 4'h0;
			flow_d_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= {flow_req_i, pause_rx_i, full_duplex_i, collision_i};
			s2_reg <= s1_reg;
			flow_d_reg <= s2_reg[3];
		end
	end
	assign fdx = s2_reg[1];
	assign coll = s2_reg[0] & ~fdx;
	assign pause_blk = param_reg[etpec_pkg::B_PAUSE] & fdx & s2_reg[2];
	assign flow_fall = flow_d_reg & ~s2_reg[3];

	assign push = load_valid_i & ready_reg;
	// Ready is registered, so it looks one push ahead and ignores this cycle's pop
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ready_reg <= 1'b0;
			hold_reg <= 1'b0;
			first_reg <= 1'b1;
		end
		else
		begin
			if (push && load_last_i && param_reg[etpec_pkg::B_SPM])
				hold_reg <= 1'b1;
			else if (pkt_done)
				hold_reg <= 1'b0;
			if (push)
				first_reg <= load_last_i;
			ready_reg <= (f_level + 5'(push) < 5'(etpec_pkg::FIFO_D)) & ~halt_reg & ~stop_ev
				& ~(hold_reg | (push & load_last_i & param_reg[etpec_pkg::B_SPM]));
		end
	end

	etpec_fifo #(
		.WIDTH(etpec_pkg::FIFO_W),
		.DEPTH(etpec_pkg::FIFO_D),
		.LW   (etpec_pkg::LVL_W)
	) u_fifo (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.in_valid_i (push),
		.in_ready_o (f_in_ready),
		.in_data_i  ({load_asis_i & first_reg, load_last_i, load_data_i}),
		.out_valid_o(f_valid),
		.out_ready_i(f_ready),
		.out_data_o (f_data),
		.level_o    (f_level)
	);

	assign late = (sent_reg == etpec_pkg::MIN_FRAME);
	assign from_rep = ~ctl_reg & (pos_reg < stored_reg);
	assign byte_val = ctl_reg ? etpec_pkg::ctl_byte(pos_reg)
		: (from_rep ? replay[6'(pos_reg)][7:0] : f_data[7:0]);
	assign byte_last = ctl_reg ? (pos_reg == etpec_pkg::CTL_LAST)
		: (from_rep ? replay[6'(pos_reg)][8] : f_data[8]);
	always_comb
	begin
		state_next = state_reg;
		emit = 1'b0;
		emit_b = 8'h00;
		f_ready = 1'b0;
		err_set = 3'h0;
		start = 1'b0;
		pkt_done = 1'b0;
		retry_set = 1'b0;
		early_coll = coll & ~late & (state_reg == etpec_pkg::ST_DATA
			|| state_reg == etpec_pkg::ST_PAD || state_reg == etpec_pkg::ST_CRC);
		late_coll = coll & late & (state_reg == etpec_pkg::ST_DATA
			|| state_reg == etpec_pkg::ST_PAD || state_reg == etpec_pkg::ST_CRC);
		underflow = (state_reg == etpec_pkg::ST_DATA) & ~coll & ~ctl_reg & ~from_rep & ~f_valid;
		unique case (state_reg)
			etpec_pkg::ST_IDLE:
				if (retry_reg || resume_reg || (!pause_blk && (pkt_reg != '0 || !f_in_ready)))
				begin
					start = 1'b1;
					state_next = etpec_pkg::ST_DATA;
				end
			etpec_pkg::ST_DATA:
				if (!coll && !underflow)
				begin
					emit = 1'b1;
					emit_b = byte_val;
					f_ready = ~ctl_reg & ~from_rep;
					if (byte_last)
					begin
						if (nocrc_reg)
							state_next = etpec_pkg::ST_GAP;
						else if (!nopad_reg && sent_reg < etpec_pkg::PAD_END)
							state_next = etpec_pkg::ST_PAD;
						else
							state_next = etpec_pkg::ST_CRC;
					end
				end
			etpec_pkg::ST_PAD:
				if (!coll)
				begin
					emit = 1'b1;
					if (sent_reg == etpec_pkg::PAD_END)
						state_next = etpec_pkg::ST_CRC;
				end
			etpec_pkg::ST_CRC:
				if (!coll)
				begin
					emit = 1'b1;
					emit_b = 8'(~crc_reg >> {cidx_reg, 3'b000});
					if (cidx_reg == 2'h3)
					begin
						state_next = etpec_pkg::ST_GAP;
						pkt_done = ~ctl_reg;
					end
				end
			etpec_pkg::ST_FLUSH:
			begin
				f_ready = 1'b1;
				if (f_valid && f_data[8])
				begin
					state_next = etpec_pkg::ST_GAP;
					pkt_done = 1'b1;
				end
			end
			etpec_pkg::ST_GAP:
				state_next = etpec_pkg::ST_IDLE;
			etpec_pkg::ST_HALT:
			begin
				f_ready = 1'b1;
				if (!halt_reg && !f_valid)
					state_next = etpec_pkg::ST_IDLE;
			end
			default:
				state_next = etpec_pkg::ST_IDLE;
		endcase
		if (early_coll)
		begin
			if (att_reg + 5'h01 >= etpec_pkg::MAX_ATTEMPT && stop_reg[etpec_pkg::B_EXC])
				err_set[etpec_pkg::B_EXC] = 1'b1;
			else
			begin
				state_next = etpec_pkg::ST_GAP;
				retry_set = 1'b1;
			end
		end
		if (late_coll)
		begin
			if (stop_reg[etpec_pkg::B_LATE])
				err_set[etpec_pkg::B_LATE] = 1'b1;
			else if (state_reg == etpec_pkg::ST_DATA)
				state_next = etpec_pkg::ST_FLUSH;
			else
				state_next = etpec_pkg::ST_GAP;
		end
		if (underflow)
		begin
			if (late && stop_reg[etpec_pkg::B_UNF])
				err_set[etpec_pkg::B_UNF] = 1'b1;
			else
				state_next = etpec_pkg::ST_FLUSH;
		end
		stop_ev = (err_set != 3'h0);
		if (stop_ev)
			state_next = etpec_pkg::ST_HALT;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			state_reg <= etpec_pkg::ST_IDLE;
		else
			state_reg <= state_next;
	end
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			resume_reg <= 1'b0;
		else if (flow_fall && !param_reg[etpec_pkg::B_RESUME_FRAME_SUPPRESS])
			resume_reg <= 1'b1;
		else if (start && !retry_reg)
			resume_reg <= 1'b0;
	end
	// A retry must keep its packet settings, replay copy and attempt count
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			retry_reg <= 1'b0;
		else if (retry_set)
			retry_reg <= 1'b1;
		else if (start)
			retry_reg <= 1'b0;
	end
	// A retry replays the first 64 bytes from a local copy; later bytes come fresh
	always_ff @(posedge clk_i)
	begin
		if (f_ready && f_valid && state_reg == etpec_pkg::ST_DATA && !stored_reg[6])
			replay[6'(stored_reg)] <= f_data[8:0];
	end
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ctl_reg <= 1'b0;
			nocrc_reg <= 1'b0;
			nopad_reg <= 1'b0;
			pos_reg <= '0;
			sent_reg <= '0;
			stored_reg <= '0;
			att_reg <= '0;
			crc_reg <= etpec_pkg::CRC_INIT;
			cidx_reg <= 2'h0;
		end
		else
		begin
			if (start && !retry_reg)
			begin
				ctl_reg <= resume_reg;
				nocrc_reg <= ~resume_reg & ~f_data[9] & param_reg[etpec_pkg::B_NOCRC];
				nopad_reg <= ~resume_reg & ~f_data[9] & param_reg[etpec_pkg::B_NOPAD]
					& ~param_reg[etpec_pkg::B_NOCRC];
				stored_reg <= '0;
				att_reg <= '0;
			end
			if (state_reg == etpec_pkg::ST_GAP || start)
			begin
				pos_reg <= '0;
				sent_reg <= '0;
				cidx_reg <= 2'h0;
				crc_reg <= etpec_pkg::CRC_INIT;
			end
			else if (emit)
			begin
				if (state_reg == etpec_pkg::ST_DATA)
					pos_reg <= pos_reg + 7'h01;
				if (!late)
					sent_reg <= sent_reg + 7'h01;
				if (state_reg == etpec_pkg::ST_CRC)
					cidx_reg <= cidx_reg + 2'h1;
				else
					crc_reg <= crc_step(crc_reg, emit_b);
			end
			if (f_ready && f_valid && state_reg == etpec_pkg::ST_DATA && !stored_reg[6])
				stored_reg <= stored_reg + 7'h01;
			if (early_coll && att_reg != etpec_pkg::MAX_ATTEMPT)
				att_reg <= att_reg + 5'h01;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			pkt_reg <= '0;
		else
			pkt_reg <= pkt_reg + 5'(push & load_last_i) - 5'(f_ready & f_valid & f_data[8]);
	end
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			en_reg <= 1'b0;
			txd_reg <= 8'h00;
		end
		else
		begin
			en_reg <= emit;
			txd_reg <= emit_b;
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign load_ready_o = ready_reg;
	assign tx_en_o = en_reg;
	assign tx_data_o = txd_reg;

	sequence s_last_byte;
		state_reg == etpec_pkg::ST_DATA && emit && byte_last;
	endsequence
	property p_spm_hold;
		@(posedge clk_i) disable iff (rst_i) hold_reg |=> !load_ready_o;
	endproperty
	a_spm_hold: assert property (p_spm_hold) else $error("load ready while held");
	property p_resume_off;
		@(posedge clk_i) disable iff (rst_i)
			!resume_reg && param_reg[etpec_pkg::B_RESUME_FRAME_SUPPRESS] |=> !resume_reg;
	endproperty
	a_resume_off: assert property (p_resume_off) else $error("resume queued");
	property p_pause;
		@(posedge clk_i) disable iff (rst_i)
			state_reg == etpec_pkg::ST_IDLE && pause_blk && !resume_reg |=> !tx_en_o ##1 !tx_en_o;
	endproperty
	a_pause: assert property (p_pause) else $error("sent during pause");
	property p_nocrc;
		@(posedge clk_i) disable iff (rst_i)
			s_last_byte and nocrc_reg && !coll |=> state_reg == etpec_pkg::ST_GAP;
	endproperty
	a_nocrc: assert property (p_nocrc) else $error("trailer after no-crc");
	property p_asis;
		@(posedge clk_i) disable iff (rst_i) start && f_data[9] |=> !nocrc_reg && !nopad_reg;
	endproperty
	a_asis: assert property (p_asis) else $error("as-is ignored");
	property p_pad;
		@(posedge clk_i) disable iff (rst_i)
			s_last_byte and !nocrc_reg && !nopad_reg && sent_reg < etpec_pkg::PAD_END && !coll
			|=> state_reg == etpec_pkg::ST_PAD;
	endproperty
	a_pad: assert property (p_pad) else $error("short frame not padded");
	property p_nopad_dis;
		@(posedge clk_i) disable iff (rst_i) nocrc_reg |-> !nopad_reg;
	endproperty
	a_nopad_dis: assert property (p_nopad_dis) else $error("pad disable honoured");
	property p_stop;
		@(posedge clk_i) disable iff (rst_i)
			stop_ev |=> state_reg == etpec_pkg::ST_HALT && halt_reg && !load_ready_o;
	endproperty
	a_stop: assert property (p_stop) else $error("no halt on error");
	property p_record;
		@(posedge clk_i) disable iff (rst_i) err_set[etpec_pkg::B_LATE] |=> err_reg[etpec_pkg::B_LATE];
	endproperty
	a_record: assert property (p_record) else $error("error not recorded");
	property p_excess;
		@(posedge clk_i) disable iff (rst_i)
			early_coll && att_reg == 5'h0F && stop_reg[etpec_pkg::B_EXC]
			|=> state_reg == etpec_pkg::ST_HALT && err_reg[etpec_pkg::B_EXC];
	endproperty
	a_excess: assert property (p_excess) else $error("excess collision ignored");
	property p_late_skip;
		@(posedge clk_i) disable iff (rst_i)
			late_coll && !stop_reg[etpec_pkg::B_LATE] |=> state_reg != etpec_pkg::ST_HALT;
	endproperty
	a_late_skip: assert property (p_late_skip) else $error("late collision halted");
	property p_reserved;
		@(posedge clk_i) disable iff (rst_i) param_reg[7:5] == 3'h0 && stop_reg[7:3] == 5'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");
endmodule
